// File: common/tcap_pkg.sv
// Package: constants, enums and carrier structs for the Type-C attach and power controller
package tcap_pkg;

  // Register byte offsets
  localparam logic [11:0] TCAP_CTRL_OFS   = 12'h000;
  localparam logic [11:0] TCAP_STATUS_OFS = 12'h004;
  localparam logic [11:0] TCAP_ID_OFS     = 12'h008;

  // Control field positions
  localparam int TCAP_CTRL_ROLE_LSB  = 0;  // 2 bits
  localparam int TCAP_CTRL_ADV_LSB   = 2;  // 2 bits
  localparam int TCAP_CTRL_FRS_EN    = 4;
  localparam int TCAP_CTRL_FRS_SEND  = 5;
  localparam int TCAP_CTRL_VCONN_EN  = 6;
  localparam int TCAP_CTRL_HV_EN     = 7;
  localparam int TCAP_CTRL_SAFE0     = 8;
  localparam int TCAP_CTRL_DB_OFF    = 9;
  localparam int TCAP_CTRL_FRS_CLR   = 10;
  localparam logic [31:0] TCAP_CTRL_RESET = 32'h0000_0000;

  // Dual-role toggle half period and safe-zero timeout
  localparam int TCAP_CLK_HZ       = 20_000_000;
  localparam int TCAP_DRP_HALF_US  = 35_000;
  localparam int TCAP_DRP_CYC      = TCAP_DRP_HALF_US * (TCAP_CLK_HZ / 1_000_000);
  localparam int TCAP_SAFE0_MS     = 650;
  localparam int TCAP_SAFE0_CYC    = TCAP_SAFE0_MS * (TCAP_CLK_HZ / 1000);

  typedef enum logic [1:0] {TCAP_ROLE_SRC, TCAP_ROLE_SNK, TCAP_ROLE_DRP} tcap_role_t;
  typedef enum logic [1:0] {TCAP_ADV_DEF, TCAP_ADV_1P5, TCAP_ADV_3P0} tcap_adv_t;
  typedef enum logic [1:0] {TCAP_PIN_OPEN, TCAP_PIN_RD, TCAP_PIN_RA} tcap_pin_t;
  typedef enum logic [2:0] {
    TCAP_CONN_NONE, TCAP_CONN_SINK, TCAP_CONN_CABLE, TCAP_CONN_CABLE_SINK,
    TCAP_CONN_DEBUG, TCAP_CONN_AUDIO, TCAP_CONN_SOURCE
  } tcap_conn_t;

  // Per-pin comparator results from the analog front end
  typedef struct packed {
    logic below_sink_detect;   // Below sink_detect_threshold for selected level
    logic below_cable_term;    // Below cable_termination_threshold
    logic below_role_swap;     // Below role_swap_detect_threshold
    logic [1:0] sink_adv;      // Partner pull-up level seen as a sink
  } tcap_cmp_t;

  // Per-pin analog controls
  typedef struct packed {
    logic pullup_en;           // source_pullup_current on
    logic pulldown_en;         // trimmed_sink_pulldown on
    logic role_swap_pd;        // role_swap_signal_pulldown on
    logic vconn_en;            // cable_supply_switch routed here
  } tcap_pinctl_t;

endpackage

// File: rtl/tcap_top.sv
// Type-C attach detection, orientation and power control with an APB register port
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module tcap_top #(
  parameter int DRP_CYC   = tcap_pkg::TCAP_DRP_CYC,
  parameter int SAFE0_CYC = tcap_pkg::TCAP_SAFE0_CYC,
  parameter logic [31:0] ID_VALUE = 32'h0000_5A01  // Arbitrary identification value
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire tcap_pkg::tcap_cmp_t  cmp_a,
  input  wire tcap_pkg::tcap_cmp_t  cmp_b,
  input  wire logic                 vbus_present,
  input  wire logic                 vbus_above_safe5v,
  input  wire logic                 vbus_at_safe0v,
  input  wire logic                 cable_input_good,
  output tcap_pkg::tcap_pinctl_t    ctl_a,
  output tcap_pkg::tcap_pinctl_t    ctl_b,
  output logic      [1:0]           adv_level,
  output logic                      vbus_source_en,
  output logic                      high_voltage_path_en,
  output logic                      vbus_pulldown_en,
  output logic                      deadbattery_pulldown_off
);

  // Counters need at least two states to time anything
  if (DRP_CYC < 2 || SAFE0_CYC < 2) begin : g_bad_counts
    $error("tcap_top: counts too small");
  end

  // APB decode
  wire logic acc      = psel & penable;
  wire logic wr       = acc & pwrite;
  wire logic hit_ctrl = paddr == tcap_pkg::TCAP_CTRL_OFS;
  wire logic hit_stat = paddr == tcap_pkg::TCAP_STATUS_OFS;
  wire logic hit_id   = paddr == tcap_pkg::TCAP_ID_OFS;
  wire logic hit_any  = hit_ctrl | hit_stat | hit_id;

  logic [31:0] ctrl_reg;
  wire logic [1:0] role_bits = ctrl_reg[tcap_pkg::TCAP_CTRL_ROLE_LSB +: 2];
  wire logic [1:0] adv_bits  = ctrl_reg[tcap_pkg::TCAP_CTRL_ADV_LSB +: 2];
  wire logic frs_en    = ctrl_reg[tcap_pkg::TCAP_CTRL_FRS_EN];
  wire logic frs_send  = ctrl_reg[tcap_pkg::TCAP_CTRL_FRS_SEND];
  wire logic vconn_req = ctrl_reg[tcap_pkg::TCAP_CTRL_VCONN_EN];
  wire logic hv_en     = ctrl_reg[tcap_pkg::TCAP_CTRL_HV_EN];
  wire logic safe0_req = ctrl_reg[tcap_pkg::TCAP_CTRL_SAFE0];
  wire logic db_off    = ctrl_reg[tcap_pkg::TCAP_CTRL_DB_OFF];

  // Control register; clear strobe bit never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= tcap_pkg::TCAP_CTRL_RESET;
    end else if (wr && hit_ctrl) begin
      ctrl_reg <= {22'h0, pwdata[9:0]};
    end
  end

  // Effective role; a role swap overrides the configured role
  logic swapped_reg;
  logic swap_to_src_reg;
  wire logic cfg_src = role_bits == 2'h0;
  wire logic cfg_drp = role_bits == 2'h2;

  // Dual-role toggle timer
  logic [31:0] drp_cnt_reg;
  logic        drp_src_reg;
  logic [1:0]  attached_conn;
  wire  logic  attached = attached_conn != 2'h0;

  // Toggle Rp and Rd while nothing is attached
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drp_cnt_reg <= 32'h0000_0000;
      drp_src_reg <= 1'b1;
    end else if (!cfg_drp || attached) begin
      drp_cnt_reg <= 32'h0000_0000;
    end else if (drp_cnt_reg == 32'(DRP_CYC - 1)) begin
      drp_cnt_reg <= 32'h0000_0000;
      drp_src_reg <= ~drp_src_reg;
    end else begin
      drp_cnt_reg <= drp_cnt_reg + 32'h0000_0001;
    end
  end

  wire logic base_src = cfg_src | (cfg_drp & drp_src_reg);
  wire logic act_src  = swapped_reg ? swap_to_src_reg : base_src;

  // Pin classification from the comparators
  wire tcap_pkg::tcap_pin_t pin_a =
    cmp_a.below_cable_term  ? tcap_pkg::TCAP_PIN_RA :
    cmp_a.below_sink_detect ? tcap_pkg::TCAP_PIN_RD :
                              tcap_pkg::TCAP_PIN_OPEN;
  wire tcap_pkg::tcap_pin_t pin_b =
    cmp_b.below_cable_term  ? tcap_pkg::TCAP_PIN_RA :
    cmp_b.below_sink_detect ? tcap_pkg::TCAP_PIN_RD :
                              tcap_pkg::TCAP_PIN_OPEN;

  // Classify the pair of pins as a source sees it
  tcap_pkg::tcap_conn_t src_conn;
  logic                 src_orient;
  always_comb begin
    src_conn   = tcap_pkg::TCAP_CONN_NONE;
    src_orient = 1'b0;
    unique case ({pin_a, pin_b})
      {tcap_pkg::TCAP_PIN_RD, tcap_pkg::TCAP_PIN_OPEN}: begin
        src_conn = tcap_pkg::TCAP_CONN_SINK;
      end
      {tcap_pkg::TCAP_PIN_OPEN, tcap_pkg::TCAP_PIN_RD}: begin
        src_conn   = tcap_pkg::TCAP_CONN_SINK;
        src_orient = 1'b1;
      end
      {tcap_pkg::TCAP_PIN_RA, tcap_pkg::TCAP_PIN_OPEN}: begin
        src_conn = tcap_pkg::TCAP_CONN_CABLE;
      end
      {tcap_pkg::TCAP_PIN_OPEN, tcap_pkg::TCAP_PIN_RA}: begin
        src_conn   = tcap_pkg::TCAP_CONN_CABLE;
        src_orient = 1'b1;
      end
      {tcap_pkg::TCAP_PIN_RA, tcap_pkg::TCAP_PIN_RD}: begin
        src_conn   = tcap_pkg::TCAP_CONN_CABLE_SINK;
        src_orient = 1'b1;
      end
      {tcap_pkg::TCAP_PIN_RD, tcap_pkg::TCAP_PIN_RA}: begin
        src_conn = tcap_pkg::TCAP_CONN_CABLE_SINK;
      end
      {tcap_pkg::TCAP_PIN_RD, tcap_pkg::TCAP_PIN_RD}: begin
        src_conn = tcap_pkg::TCAP_CONN_DEBUG;
      end
      {tcap_pkg::TCAP_PIN_RA, tcap_pkg::TCAP_PIN_RA}: begin
        src_conn = tcap_pkg::TCAP_CONN_AUDIO;
      end
      default: begin
        src_conn = tcap_pkg::TCAP_CONN_NONE;
      end
    endcase
  end

  // Connection state and orientation
  tcap_pkg::tcap_conn_t conn_reg;
  logic                 orient_reg;
  logic                 frs_flag_reg;
  wire logic mon_a_high = !cmp_a.below_sink_detect;
  wire logic mon_b_high = !cmp_b.below_sink_detect;
  wire logic mon_pin_high = orient_reg ? mon_b_high : mon_a_high;

  // Detach: sink pin only for Rd cases, either pin for accessories
  logic src_detach;
  always_comb begin
    src_detach = 1'b0;
    unique case (conn_reg)
      tcap_pkg::TCAP_CONN_SINK:       src_detach = mon_pin_high;
      tcap_pkg::TCAP_CONN_CABLE_SINK: src_detach = mon_pin_high;
      tcap_pkg::TCAP_CONN_CABLE: begin
        src_detach = (orient_reg ? !cmp_b.below_cable_term : !cmp_a.below_cable_term)
                   | (src_conn != tcap_pkg::TCAP_CONN_CABLE);
      end
      tcap_pkg::TCAP_CONN_DEBUG:      src_detach = mon_a_high | mon_b_high;
      tcap_pkg::TCAP_CONN_AUDIO: begin
        src_detach = !cmp_a.below_cable_term | !cmp_b.below_cable_term;
      end
      default: src_detach = 1'b0;
    endcase
  end

  // Sink side orientation from whichever pin carries the pull-up
  wire logic snk_orient = cmp_b.sink_adv > cmp_a.sink_adv;
  wire logic frs_detect = !act_src & frs_en & (conn_reg == tcap_pkg::TCAP_CONN_SOURCE)
                        & (orient_reg ? cmp_b.below_role_swap : cmp_a.below_role_swap);

  // Attach state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conn_reg   <= tcap_pkg::TCAP_CONN_NONE;
      orient_reg <= 1'b0;
    end else if (act_src) begin
      if (conn_reg == tcap_pkg::TCAP_CONN_NONE || conn_reg == tcap_pkg::TCAP_CONN_SOURCE) begin
        conn_reg   <= src_conn;
        orient_reg <= src_orient;
      end else if (conn_reg == tcap_pkg::TCAP_CONN_CABLE
                   && src_conn == tcap_pkg::TCAP_CONN_CABLE_SINK) begin
        conn_reg   <= src_conn;
        orient_reg <= src_orient;
      end else if (src_detach) begin
        conn_reg <= tcap_pkg::TCAP_CONN_NONE;
      end
    end else begin
      if (!vbus_present) begin
        conn_reg <= tcap_pkg::TCAP_CONN_NONE;
      end else if (conn_reg != tcap_pkg::TCAP_CONN_SOURCE) begin
        conn_reg   <= tcap_pkg::TCAP_CONN_SOURCE;
        orient_reg <= snk_orient;
      end
    end
  end

  assign attached_conn = (conn_reg == tcap_pkg::TCAP_CONN_NONE) ? 2'h0 : 2'h1;

  // Fast role swap: flag and role override; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frs_flag_reg    <= 1'b0;
      swapped_reg     <= 1'b0;
      swap_to_src_reg <= 1'b0;
    end else begin
      if (frs_detect) begin
        frs_flag_reg    <= 1'b1;
        swapped_reg     <= 1'b1;
        swap_to_src_reg <= 1'b1;
      end else if (act_src && frs_en && frs_send && conn_reg == tcap_pkg::TCAP_CONN_SINK) begin
        swapped_reg     <= 1'b1;
        swap_to_src_reg <= 1'b0;
      end else if (wr && hit_ctrl && pwdata[tcap_pkg::TCAP_CTRL_FRS_CLR]) begin
        frs_flag_reg <= 1'b0;
        swapped_reg  <= 1'b0;
      end
    end
  end

  // Cable supply switch: closes only with input good, then latched
  logic vconn_on_reg;
  wire logic vconn_want = act_src & vconn_req & (conn_reg == tcap_pkg::TCAP_CONN_CABLE_SINK);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vconn_on_reg <= 1'b0;
    end else if (!vconn_want) begin
      vconn_on_reg <= 1'b0;
    end else if (!vconn_on_reg && cable_input_good) begin
      vconn_on_reg <= 1'b1;
    end
  end

  // VBUS discharge: to vSafe5V when path off, to vSafe0V on request with timeout
  logic [31:0] safe0_cnt_reg;
  logic        safe0_timeout_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safe0_cnt_reg     <= 32'h0000_0000;
      safe0_timeout_reg <= 1'b0;
    end else if (!safe0_req || vbus_at_safe0v) begin
      safe0_cnt_reg     <= 32'h0000_0000;
      safe0_timeout_reg <= 1'b0;
    end else if (safe0_cnt_reg == 32'(SAFE0_CYC - 1)) begin
      safe0_timeout_reg <= 1'b1;
    end else begin
      safe0_cnt_reg <= safe0_cnt_reg + 32'h0000_0001;
    end
  end

  wire logic safe5_pd = !hv_en & vbus_above_safe5v;
  wire logic safe0_pd = safe0_req & !vbus_at_safe0v;
  wire logic src_pow  = act_src & ((conn_reg == tcap_pkg::TCAP_CONN_SINK)
                      | (conn_reg == tcap_pkg::TCAP_CONN_CABLE_SINK));

  // Pin controls; VCONN goes to the Ra pin, opposite the sink pin
  always_comb begin
    ctl_a = '0;
    ctl_b = '0;
    ctl_a.pullup_en    = act_src;
    ctl_b.pullup_en    = act_src;
    ctl_a.pulldown_en  = !act_src & db_off;
    ctl_b.pulldown_en  = !act_src & db_off;
    ctl_a.vconn_en     = vconn_on_reg & orient_reg;
    ctl_b.vconn_en     = vconn_on_reg & !orient_reg;
    ctl_a.role_swap_pd = act_src & frs_en & frs_send & !orient_reg;
    ctl_b.role_swap_pd = act_src & frs_en & frs_send & orient_reg;
  end

  assign adv_level                = adv_bits;
  assign vbus_source_en           = src_pow;
  assign high_voltage_path_en     = hv_en;
  assign vbus_pulldown_en         = safe5_pd | safe0_pd;
  assign deadbattery_pulldown_off = db_off;

  // Read mux; unmapped addresses answer with slave error
  wire logic [31:0] status_word = {19'h00000, safe0_timeout_reg, vconn_on_reg,
                                   swapped_reg, frs_flag_reg, act_src, orient_reg,
                                   1'b0, conn_reg, vbus_present, 1'b0, 1'b0};
  assign pready  = 1'b1;
  assign pslverr = acc & !hit_any;

  // Registered read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit_ctrl ? ctrl_reg : hit_stat ? status_word : hit_id ? ID_VALUE : 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// File: tb/tcap_monitor.sv
// Port assertions for the Type-C attach and power controller
`timescale 1ns/10ps
`default_nettype none
module tcap_monitor (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pslverr,
  input wire tcap_pkg::tcap_cmp_t    cmp_a,
  input wire tcap_pkg::tcap_cmp_t    cmp_b,
  input wire logic                   vbus_above_safe5v,
  input wire logic                   cable_input_good,
  input wire tcap_pkg::tcap_pinctl_t ctl_a,
  input wire tcap_pkg::tcap_pinctl_t ctl_b,
  input wire logic [1:0]             adv_level,
  input wire logic                   vbus_source_en,
  input wire logic                   high_voltage_path_en,
  input wire logic                   vbus_pulldown_en,
  input wire logic                   deadbattery_pulldown_off
);
  logic [1:0] role_reg;
  logic       frs_reg;
  // Bus decode and pin terminations as the comparators report them
  wire ctrl_wr = psel && penable && pwrite && paddr == tcap_pkg::TCAP_CTRL_OFS;
  wire mapped  = paddr inside {tcap_pkg::TCAP_CTRL_OFS, tcap_pkg::TCAP_STATUS_OFS,
                               tcap_pkg::TCAP_ID_OFS};
  wire src     = role_reg == 2'h0 && !frs_reg;
  wire snk     = role_reg == 2'h1 && !frs_reg;
  wire open_a  = !cmp_a.below_sink_detect;
  wire open_b  = !cmp_b.below_sink_detect;
  wire nopwr   = !vbus_source_en && !ctl_a.vconn_en && !ctl_b.vconn_en;
  // Shadow of role and swap enable; swap modes are kept out of the role checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role_reg <= 2'h0;
      frs_reg  <= 1'h0;
    end else if (ctrl_wr) begin
      role_reg <= pwdata[1:0];
      frs_reg  <= pwdata[4];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ctrl_wr;
    ctrl_wr;
  endsequence
  sequence s_open;
    (src && open_a && open_b) [*4];
  endsequence
  sequence s_cable;
    (src && (cmp_a.below_cable_term && open_b || open_a && cmp_b.below_cable_term)) [*4];
  endsequence
  a_bad_addr_err:
    assert property (psel && penable && !mapped |-> pslverr) else $error("no slave error");
  a_adv_level_wr:
    assert property (s_ctrl_wr |=> adv_level == $past(pwdata[3:2])) else $error("adv lost");
  a_db_off_wr:
    assert property (s_ctrl_wr |=> deadbattery_pulldown_off == $past(pwdata[9]))
    else $error("dead battery control lost");
  a_open_no_power:
    assert property (s_open |-> nopwr) else $error("power with nothing attached");
  a_cable_no_power:
    assert property (s_cable |-> nopwr) else $error("power to cable without sink");
  a_src_pullups:
    assert property (src |-> ctl_a.pullup_en && ctl_b.pullup_en) else $error("pull-up off");
  a_sink_pulldowns:
    assert property (snk && deadbattery_pulldown_off |-> ctl_a.pulldown_en && ctl_b.pulldown_en
      && !ctl_a.pullup_en && !ctl_b.pullup_en) else $error("sink termination wrong");
  a_vconn_gate:
    assert property ($rose(ctl_a.vconn_en) || $rose(ctl_b.vconn_en) |->
      cable_input_good || $past(cable_input_good)) else $error("cable switch closed on bad input");
  a_vbus_drain:
    assert property ((!high_voltage_path_en && vbus_above_safe5v) [*2] |-> vbus_pulldown_en)
    else $error("no VBUS discharge");
endmodule
bind tcap_top tcap_monitor tcap_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .cmp_a(cmp_a), .cmp_b(cmp_b),
  .vbus_above_safe5v(vbus_above_safe5v), .cable_input_good(cable_input_good),
  .ctl_a(ctl_a), .ctl_b(ctl_b), .adv_level(adv_level), .vbus_source_en(vbus_source_en),
  .high_voltage_path_en(high_voltage_path_en), .vbus_pulldown_en(vbus_pulldown_en),
  .deadbattery_pulldown_off(deadbattery_pulldown_off));
`default_nettype wire

// File: tb/tcap_partner.sv
// Behavioural Type-C port partner turning its terminations into comparator levels
`timescale 1ns/10ps
`default_nettype none
module tcap_partner (
  input wire logic [1:0]             kind_a,
  input wire logic [1:0]             kind_b,
  input wire logic                   is_source,
  input wire logic                   swap_pull,
  input wire tcap_pkg::tcap_pinctl_t ctl_a,
  input wire tcap_pkg::tcap_pinctl_t ctl_b,
  input wire logic                   db_off,
  output tcap_pkg::tcap_cmp_t        cmp_a,
  output tcap_pkg::tcap_cmp_t        cmp_b,
  output logic                       vbus_present
);
  // Device pull-up over our termination, our own pull-up, or a grounded pin
  function automatic tcap_pkg::tcap_cmp_t level(input logic [1:0] k,
    input logic pu, input logic ps, input logic sw);
    tcap_pkg::tcap_cmp_t c;
    c = '{1'b1, 1'b1, 1'b1, 2'h0};
    if (pu) begin
      c = '{k != tcap_pkg::TCAP_PIN_OPEN, k == tcap_pkg::TCAP_PIN_RA, 1'b0, 2'h0};
    end else if (ps && k != tcap_pkg::TCAP_PIN_OPEN) begin
      c = '{1'b0, 1'b0, sw, 2'h1};
    end
    return c;
  endfunction
  assign cmp_a = level(kind_a, ctl_a.pullup_en, is_source, swap_pull);
  assign cmp_b = level(kind_b, ctl_b.pullup_en, is_source, 1'b0);
  // VBUS only once a pull-down is seen, the trimmed one or the dead-battery one
  assign vbus_present = is_source && kind_a != tcap_pkg::TCAP_PIN_OPEN
                        && (ctl_a.pulldown_en || !db_off);
endmodule
`default_nettype wire

// File: tb/typec_attach_power_control_test.sv
// Self-checking bench for the Type-C attach and power controller
`timescale 1ns/10ps
`default_nettype none
module typec_attach_power_control_test;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, st, r;
  tcap_pkg::tcap_cmp_t    cmp_a, cmp_b;
  tcap_pkg::tcap_pinctl_t ctl_a, ctl_b;
  logic [1:0]             kind_a, kind_b;
  logic                   vbus_present, vbus_above_safe5v, vbus_at_safe0v, cable_input_good;
  logic                   vbus_source_en, high_voltage_path_en, vbus_pulldown_en;
  logic                   deadbattery_pulldown_off, is_source, swap_pull;
  logic [1:0]             adv_level, seen;
  int                     err_count, checks_done, cycles, seed;
  localparam logic [3:0]  pin_tab [9] = '{4'h0, 4'h4, 4'h1, 4'h8, 4'h2, 4'h9, 4'h6, 4'h5, 4'hA};
  // Identification value is arbitrary; short counts keep the run brief
  tcap_top #(.DRP_CYC(8), .SAFE0_CYC(16), .ID_VALUE(32'h0000_3C5A)) tcap_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_a(cmp_a), .cmp_b(cmp_b), .vbus_present(vbus_present),
    .vbus_above_safe5v(vbus_above_safe5v), .vbus_at_safe0v(vbus_at_safe0v),
    .cable_input_good(cable_input_good), .ctl_a(ctl_a), .ctl_b(ctl_b), .adv_level(adv_level),
    .vbus_source_en(vbus_source_en), .high_voltage_path_en(high_voltage_path_en),
    .vbus_pulldown_en(vbus_pulldown_en), .deadbattery_pulldown_off(deadbattery_pulldown_off));
  tcap_partner tcap_partner_i (.kind_a(kind_a), .kind_b(kind_b), .is_source(is_source),
    .swap_pull(swap_pull), .ctl_a(ctl_a), .ctl_b(ctl_b), .db_off(deadbattery_pulldown_off),
    .cmp_a(cmp_a), .cmp_b(cmp_b), .vbus_present(vbus_present));
  // Clock, and a cycle ceiling so a hang still ends in the report
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer; the idle edge first keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    st = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic logic [2:0] exp_conn(input logic [3:0] ab);
    case (ab)
      4'h1, 4'h4: return 3'h1;
      4'h2, 4'h8: return 3'h2;
      4'h6, 4'h9: return 3'h3;
      4'h5:       return 3'h4;
      4'hA:       return 3'h5;
      default:    return 3'h0;
    endcase
  endfunction
  // Detach, attach the given pair of terminations, then judge state and power
  task automatic try_pins(input logic [3:0] ab);
    logic [2:0] ec;
    ec = exp_conn(ab);
    @(posedge pclk);
    {kind_a, kind_b} <= 4'h0;
    wait_cyc(5);
    chk(vbus_source_en, 32'h0);
    {kind_a, kind_b} <= ab;
    wait_cyc(5);
    apb(1'b0, tcap_pkg::TCAP_STATUS_OFS, 32'h0);
    chk(st[5:3], ec);
    if (ec == 3'h1 || ec == 3'h3) chk({st[7], vbus_source_en, ctl_a.vconn_en, ctl_b.vconn_en},
      {ab == 4'h1 || ab == 4'h9, 1'b1, ab == 4'h9, ab == 4'h6});
    if (ec == 3'h0 || ec == 3'h2) chk({vbus_source_en, ctl_a.vconn_en}, 32'h0);
  endtask
  task automatic end_of_test();
    $display("checks_done %0d err_count %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, is_source, swap_pull} = '0;
    {kind_a, kind_b, vbus_above_safe5v, vbus_at_safe0v, cable_input_good} = 7'h01;
    {err_count, checks_done, cycles, seed} = {32'h0, 32'h0, 32'h0, 32'h45};
    rst();
    apb(1'b0, tcap_pkg::TCAP_CTRL_OFS, 32'h0);
    chk(st, tcap_pkg::TCAP_CTRL_RESET);
    apb(1'b0, tcap_pkg::TCAP_ID_OFS, 32'h0);
    chk(st, 32'h0000_3C5A);
    apb(1'b0, 12'h00C, 32'h0);
    chk({er, st[30:0]}, 32'h8000_0000);
    // Every termination pair and advertisement level, then random ones
    for (int i = 0; i < 21; i++) begin
      r = (i < 9) ? {26'h0, pin_tab[i], 2'(i % 3)} : $random(seed);
      apb(1'b1, tcap_pkg::TCAP_CTRL_OFS, {24'h0, 4'h4, r[1:0] % 2'h3, 2'h0});
      try_pins((i < 9) ? r[5:2] : {r[5:4] % 2'h3, r[3:2] % 2'h3});
      chk(adv_level, r[1:0] % 2'h3);
    end
    // Cable supply stays closed on input loss; Ra pin is not watched for detach
    try_pins(4'h9);
    cable_input_good <= 1'b0;
    wait_cyc(4);
    chk(ctl_a.vconn_en, 32'h1);
    kind_a <= tcap_pkg::TCAP_PIN_OPEN;
    wait_cyc(4);
    chk(vbus_source_en, 32'h1);
    kind_b <= tcap_pkg::TCAP_PIN_OPEN;
    wait_cyc(5);
    {kind_a, kind_b} <= 4'h9;
    wait_cyc(6);
    chk({vbus_source_en, ctl_a.vconn_en}, 32'h2);
    // Sink: partner sources after seeing a pull-down, then asks for a role swap
    rst();
    apb(1'b1, tcap_pkg::TCAP_CTRL_OFS, 32'h1);
    {is_source, kind_a, kind_b} <= 5'h14;
    wait_cyc(6);
    apb(1'b0, tcap_pkg::TCAP_STATUS_OFS, 32'h0);
    chk({st[5:2], deadbattery_pulldown_off}, 32'h1A);
    apb(1'b1, tcap_pkg::TCAP_CTRL_OFS, 32'h201);
    apb(1'b1, tcap_pkg::TCAP_CTRL_OFS, 32'h211);
    swap_pull <= 1'b1;
    wait_cyc(4);
    apb(1'b0, tcap_pkg::TCAP_STATUS_OFS, 32'h0);
    chk({st[9:8], deadbattery_pulldown_off}, 32'h7);
    swap_pull <= 1'b0;
    apb(1'b1, tcap_pkg::TCAP_CTRL_OFS, 32'h611);
    apb(1'b0, tcap_pkg::TCAP_STATUS_OFS, 32'h0);
    chk(st[9], 32'h0);
    // Source with a sink on pin b signals a swap on that pin only
    rst();
    {is_source, kind_a, kind_b} <= 5'h01;
    apb(1'b1, tcap_pkg::TCAP_CTRL_OFS, 32'h10);
    apb(1'b1, tcap_pkg::TCAP_CTRL_OFS, 32'h30);
    // The swap pull-down stands only until the swap takes effect
    @(negedge pclk);
    chk({ctl_a.role_swap_pd, ctl_b.role_swap_pd}, 32'h1);
    apb(1'b0, tcap_pkg::TCAP_STATUS_OFS, 32'h0);
    chk({st[10], st[8]}, 32'h2);
    // Dual role toggles its pull-up while nothing is attached
    rst();
    kind_b <= tcap_pkg::TCAP_PIN_OPEN;
    apb(1'b1, tcap_pkg::TCAP_CTRL_OFS, 32'h2);
    seen = 2'h0;
    repeat (40) begin
      @(posedge pclk);
      seen = seen | {ctl_a.pullup_en === 1'b1, ctl_a.pullup_en === 1'b0};
    end
    chk(seen, 32'h3);
    // Discharge to the safe levels
    vbus_above_safe5v <= 1'b1;
    wait_cyc(4);
    chk(vbus_pulldown_en, 32'h1);
    apb(1'b1, tcap_pkg::TCAP_CTRL_OFS, 32'h82);
    wait_cyc(2);
    chk({high_voltage_path_en, vbus_pulldown_en}, 32'h2);
    vbus_above_safe5v <= 1'b0;
    wait_cyc(4);
    chk(vbus_pulldown_en, 32'h0);
    apb(1'b1, tcap_pkg::TCAP_CTRL_OFS, 32'h100);
    wait_cyc(8);
    chk(vbus_pulldown_en, 32'h1);
    wait_cyc(12);
    apb(1'b0, tcap_pkg::TCAP_STATUS_OFS, 32'h0);
    chk(st[12], 32'h1);
    vbus_at_safe0v <= 1'b1;
    wait_cyc(4);
    chk(vbus_pulldown_en, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
